// File: hdl/kmm_params.svh
`ifndef KMM_PARAMS_SVH
`define KMM_PARAMS_SVH
// Memory controller native data width in bits.
`define KMM_DATA_W 512
// Address width of the memory master.
`define KMM_ADDR_W 64
// Log2 of the bytes carried by one full-width beat.
`define KMM_BEAT_LOG2 6
// Largest burst in beats: one 4 KB page of full beats.
`define KMM_PAGE_BEATS 7'h40
// Size of one protocol page in bytes.
`define KMM_PAGE_BYTES 13'h1000
// Most bursts kept in flight per direction.
`define KMM_MAX_OUT 4
// Burst type code for incrementing bursts.
`define KMM_BURST_INCR 2'h1
// Size code for a 64-byte full-width beat.
`define KMM_SIZE_FULL 3'h6
// The single transaction ID used on both directions.
`define KMM_ID_VALUE 1'h0
// Clock numbers used when frequencies are assigned.
`define KMM_CLK_ID_PRIMARY 1'h0
`define KMM_CLK_ID_SECONDARY 1'h1
`endif

// File: hdl/kmm_pkg.sv
package kmm_pkg;
  // One user command: a run of full beats to move.
  typedef struct packed {
    logic write;
    logic [63:0] addr;
    logic [15:0] beats;
  } cmd_s;
  // Command engine states, Gray coded along the path.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DRAIN = 2'h3
  } eng_state_e;
endpackage

// File: hdl/kernel_mem_master.sv
`timescale 1ns/1ps
`include "kmm_params.svh"
// What this block does
// - Primary clock mandatory, secondary clock optional.
// - All interfaces synchronous to primary clock.
// - Cross-domain signals pass a synchronizer.
// - Wait for synthesizer lock before operating.
// - Primary clock is ID 0, secondary ID 1.
// - Data bus equals 512-bit controller width.
// - Only incrementing, full-size bursts.
// - Longest bursts, never crossing 4 KB.
// - Every write strobe bit always set.
// - Keep several transactions outstanding.
// - Use one transaction ID only.
// - Write address only when data ready.
// - Read address only when data absorbable.
// - Unused channel ports may be omitted.
// - Pipeline resets, avoid high fanout.
// - Reset control state, not datapath.
// - Register signals at the boundary; wr_ready is combinational from m_axi_wready.
// - Die crossings run flop to flop.
module kernel_mem_master #(
  parameter int DATA_W = `KMM_DATA_W,
  parameter int MAX_OUT = `KMM_MAX_OUT
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Lock indication from the internal synthesizer.
  input wire logic synth_locked,
  output logic active_clock_id,
  // User command port.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire kmm_pkg::cmd_s cmd,
  output logic cmd_done,
  // User write data source.
  input wire logic [15:0] wr_avail,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  // User read data sink, never stalled.
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // Write address channel.
  output logic m_axi_awvalid,
  input wire logic m_axi_awready,
  output logic [63:0] m_axi_awaddr,
  output logic [7:0] m_axi_awlen,
  output logic [2:0] m_axi_awsize,
  output logic [1:0] m_axi_awburst,
  output logic m_axi_awid,
  // Write data channel.
  output logic m_axi_wvalid,
  input wire logic m_axi_wready,
  output logic [DATA_W-1:0] m_axi_wdata,
  output logic [DATA_W/8-1:0] m_axi_wstrb,
  output logic m_axi_wlast,
  // Write response channel.
  input wire logic m_axi_bvalid,
  output logic m_axi_bready,
  // Read address channel.
  output logic m_axi_arvalid,
  input wire logic m_axi_arready,
  output logic [63:0] m_axi_araddr,
  output logic [7:0] m_axi_arlen,
  output logic [2:0] m_axi_arsize,
  output logic [1:0] m_axi_arburst,
  output logic m_axi_arid,
  // Read data channel.
  input wire logic m_axi_rvalid,
  output logic m_axi_rready,
  input wire logic [DATA_W-1:0] m_axi_rdata,
  input wire logic m_axi_rlast
);
  // ----------------------------------------
  // Reset pipeline and lock synchronizer
  // ----------------------------------------
  logic [1:0] rst_pipe_ff; // Registered copies of the reset.
  logic lock_meta_ff; // First synchronizer stage.
  logic lock_sync_ff; // Lock, safe in this domain.
  logic ctl_rst_ff; // Local reset for control state.

  // The reset is staged so each leaf sees a short local net.
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rst_pipe_ff <= {rst_pipe_ff[0], reset};
    end
  end

  // Lock comes from the synthesizer's own domain.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lock_meta_ff <= 1'b0;
      lock_sync_ff <= 1'b0;
    end else if (clk_en) begin
      lock_meta_ff <= synth_locked;
      lock_sync_ff <= lock_meta_ff;
    end
  end

  // Control logic stays in reset until lock is seen.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl_rst_ff <= 1'b1;
    end else if (clk_en) begin
      ctl_rst_ff <= rst_pipe_ff[1] | ~lock_sync_ff;
    end
  end

  // Every port here runs on the primary clock, number 0.
  assign active_clock_id = `KMM_CLK_ID_PRIMARY;

  // ----------------------------------------
  // Command engine
  // ----------------------------------------
  kmm_pkg::eng_state_e state_ff; // Engine state.
  logic dir_wr_ff; // Current command writes.
  logic [63:0] addr_ff; // Next burst address.
  logic [15:0] remain_ff; // Beats still to request.
  logic [6:0] page_left; // Beats up to the 4 KB edge.
  logic [6:0] blen; // Beats in the next burst.
  logic [2:0] wr_out_ff; // Write bursts in flight.
  logic [2:0] rd_out_ff; // Read bursts in flight.
  logic [15:0] w_owed_ff; // Write beats promised, not yet taken.
  logic issue; // A burst address is launched now.
  logic can_issue; // Flow conditions allow a burst.
  logic aw_take; // Write address accepted.
  logic ar_take; // Read address accepted.
  logic w_load; // A beat enters the write stage.
  logic b_take; // Write response accepted.
  logic r_end; // Last read beat accepted.

  // Bursts stop at the page edge and never exceed one page.
  assign page_left = `KMM_PAGE_BEATS - {1'b0, addr_ff[11:6]};
  assign blen = (remain_ff < {9'h0, page_left}) ? remain_ff[6:0] : page_left;

  // A write burst needs all its beats already in the source.
  always_comb begin
    if (dir_wr_ff) begin
      can_issue = !m_axi_awvalid && (wr_out_ff < 3'(MAX_OUT))
                  && ({16'h0, wr_avail} >= {16'h0, w_owed_ff} + {25'h0, blen});
    end else begin
      can_issue = !m_axi_arvalid && (rd_out_ff < 3'(MAX_OUT));
    end
  end

  assign issue = (state_ff == kmm_pkg::ST_RUN) && (remain_ff != 16'h0) && can_issue;
  assign aw_take = m_axi_awvalid && m_axi_awready;
  assign ar_take = m_axi_arvalid && m_axi_arready;
  assign b_take = m_axi_bvalid && m_axi_bready;
  assign r_end = m_axi_rvalid && m_axi_rready && m_axi_rlast;
  assign cmd_ready = (state_ff == kmm_pkg::ST_IDLE) && !ctl_rst_ff;

  // Sequence commands; draining waits for every burst to finish.
  always_ff @(posedge sys_clk) begin
    if (ctl_rst_ff) begin
      state_ff <= kmm_pkg::ST_IDLE;
      cmd_done <= 1'b0;
    end else if (clk_en) begin
      cmd_done <= 1'b0;
      case (state_ff)
        kmm_pkg::ST_IDLE: begin
          if (cmd_valid) begin
            state_ff <= kmm_pkg::ST_RUN;
          end
        end
        kmm_pkg::ST_RUN: begin
          if (remain_ff == 16'h0) begin
            state_ff <= kmm_pkg::ST_DRAIN;
          end
        end
        kmm_pkg::ST_DRAIN: begin
          // Done only once nothing is in flight in either direction.
          if (!m_axi_awvalid && !m_axi_arvalid && wr_out_ff == 3'h0 && rd_out_ff == 3'h0
              && w_owed_ff == 16'h0 && !m_axi_wvalid) begin
            state_ff <= kmm_pkg::ST_IDLE;
            cmd_done <= 1'b1;
          end
        end
        default: begin
          state_ff <= kmm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Address and count walk; datapath-like, so left without reset.
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (cmd_valid && cmd_ready) begin
        dir_wr_ff <= cmd.write;
        addr_ff <= {cmd.addr[63:6], 6'h0};
        remain_ff <= cmd.beats;
      end else if (issue) begin
        addr_ff <= addr_ff + {51'h0, blen, 6'h0};
        remain_ff <= remain_ff - {9'h0, blen};
      end
    end
  end

  // ----------------------------------------
  // Address channels
  // ----------------------------------------
  // Valids are control state; address fields are held data.
  always_ff @(posedge sys_clk) begin
    if (ctl_rst_ff) begin
      m_axi_awvalid <= 1'b0;
      m_axi_arvalid <= 1'b0;
    end else if (clk_en) begin
      if (issue && dir_wr_ff) begin
        m_axi_awvalid <= 1'b1;
      end else if (aw_take) begin
        m_axi_awvalid <= 1'b0;
      end
      if (issue && !dir_wr_ff) begin
        m_axi_arvalid <= 1'b1;
      end else if (ar_take) begin
        m_axi_arvalid <= 1'b0;
      end
    end
  end

  // Address fields are registered at the boundary.
  always_ff @(posedge sys_clk) begin
    if (clk_en && issue) begin
      m_axi_awaddr <= addr_ff;
      m_axi_araddr <= addr_ff;
      m_axi_awlen <= {1'b0, blen - 7'h1};
      m_axi_arlen <= {1'b0, blen - 7'h1};
    end
  end

  // Fixed attributes: full beats, incrementing, one ID.
  assign m_axi_awsize = `KMM_SIZE_FULL;
  assign m_axi_arsize = `KMM_SIZE_FULL;
  assign m_axi_awburst = `KMM_BURST_INCR;
  assign m_axi_arburst = `KMM_BURST_INCR;
  assign m_axi_awid = `KMM_ID_VALUE;
  assign m_axi_arid = `KMM_ID_VALUE;

  // Count bursts in flight; the limit keeps the pipe full yet bounded.
  always_ff @(posedge sys_clk) begin
    if (ctl_rst_ff) begin
      wr_out_ff <= 3'h0;
      rd_out_ff <= 3'h0;
    end else if (clk_en) begin
      wr_out_ff <= wr_out_ff + 3'(issue && dir_wr_ff) - 3'(b_take);
      rd_out_ff <= rd_out_ff + 3'(issue && !dir_wr_ff) - 3'(r_end);
    end
  end

  // ----------------------------------------
  // Write data path
  // ----------------------------------------
  logic [6:0] wlen_mem [MAX_OUT]; // Beat counts per burst, in order.
  logic [1:0] wq_wr_ff; // Ring write pointer.
  logic [1:0] wq_rd_ff; // Ring read pointer.
  logic [6:0] wbeat_ff; // Beat index inside the current burst.

  // One ring slot per burst in flight, so it never overflows.
  always_ff @(posedge sys_clk) begin
    if (clk_en && issue && dir_wr_ff) begin
      wlen_mem[wq_wr_ff] <= blen;
    end
  end

  assign w_load = wr_valid && wr_ready;
  assign wr_ready = (w_owed_ff != 16'h0) && (!m_axi_wvalid || m_axi_wready);

  // Promised beats rise at issue and fall as the source delivers.
  always_ff @(posedge sys_clk) begin
    if (ctl_rst_ff) begin
      w_owed_ff <= 16'h0;
      wq_wr_ff <= 2'h0;
      wq_rd_ff <= 2'h0;
      wbeat_ff <= 7'h0;
    end else if (clk_en) begin
      w_owed_ff <= w_owed_ff + ((issue && dir_wr_ff) ? {9'h0, blen} : 16'h0) - 16'(w_load);
      if (issue && dir_wr_ff) begin
        wq_wr_ff <= wq_wr_ff + 2'h1;
      end
      if (w_load) begin
        if (wbeat_ff == wlen_mem[wq_rd_ff] - 7'h1) begin
          wbeat_ff <= 7'h0;
          wq_rd_ff <= wq_rd_ff + 2'h1;
        end else begin
          wbeat_ff <= wbeat_ff + 7'h1;
        end
      end
    end
  end

  // Stage valid is control; held until the slave takes the beat.
  always_ff @(posedge sys_clk) begin
    if (ctl_rst_ff) begin
      m_axi_wvalid <= 1'b0;
    end else if (clk_en) begin
      if (w_load) begin
        m_axi_wvalid <= 1'b1;
      end else if (m_axi_wready) begin
        m_axi_wvalid <= 1'b0;
      end
    end
  end

  // Data and last flag are flop to flop, with no reset.
  always_ff @(posedge sys_clk) begin
    if (clk_en && w_load) begin
      m_axi_wdata <= wr_data;
      m_axi_wlast <= (wbeat_ff == wlen_mem[wq_rd_ff] - 7'h1);
    end
  end

  // Partial strobes would force read-modify-write in the controller.
  assign m_axi_wstrb = '1;
  // Both directions are kept; a one-way user could drop the other channels.
  assign m_axi_bready = 1'b1;

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  // Read data is always accepted; the sink must keep up.
  assign m_axi_rready = 1'b1;

  always_ff @(posedge sys_clk) begin
    if (ctl_rst_ff) begin
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= m_axi_rvalid;
    end
  end

  // Read data register carries no reset.
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= m_axi_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence seq_unlocked;
    (!synth_locked && clk_en) [*4];
  endsequence

  AST_BURST_KIND: assert property (m_axi_awvalid |-> m_axi_awburst == 2'h1 && m_axi_awsize == 3'h6)
    else $error("write burst not full-size incrementing");
  AST_PAGE_EDGE: assert property (m_axi_arvalid |->
    {1'b0, m_axi_araddr[11:0]} + {m_axi_arlen[6:0] + 7'h1, 6'h0} <= 14'h1000)
    else $error("read burst crosses a 4 KB page");
  AST_STROBES: assert property (m_axi_wvalid |-> &m_axi_wstrb)
    else $error("write beat with a cleared strobe");
  AST_ONE_ID: assert property (m_axi_awvalid || m_axi_arvalid |-> !m_axi_awid && !m_axi_arid)
    else $error("transaction ID other than zero");
  AST_NO_READ_STALL: assert property (!ctl_rst_ff |-> m_axi_rready)
    else $error("read data channel stalled");
  AST_LOCK_HOLD: assert property (seq_unlocked |=> !m_axi_awvalid && !m_axi_arvalid && !m_axi_wvalid)
    else $error("valid raised without lock");
  AST_READ_REG: assert property (m_axi_rvalid && clk_en && !ctl_rst_ff |=>
    rd_valid && rd_data == $past(m_axi_rdata))
    else $error("read data not registered one cycle later");
  AST_IN_FLIGHT: assert property (wr_out_ff <= 3'(MAX_OUT) && rd_out_ff <= 3'(MAX_OUT))
    else $error("too many bursts in flight");
endmodule

// File: verif/mem_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behavioural memory controller facing the memory master.
// ------------------------------------------------------------
module mem_ctrl_model (
  // Clock and pacing; slow makes every channel ready on alternate cycles.
  input wire logic sys_clk,
  input wire logic slow,
  // Write channels.
  input wire logic m_axi_awvalid,
  output logic m_axi_awready,
  input wire logic m_axi_wvalid,
  output logic m_axi_wready,
  input wire logic m_axi_wlast,
  output logic m_axi_bvalid,
  input wire logic m_axi_bready,
  // Read channels.
  input wire logic m_axi_arvalid,
  output logic m_axi_arready,
  input wire logic [63:0] m_axi_araddr,
  input wire logic [7:0] m_axi_arlen,
  output logic m_axi_rvalid,
  input wire logic m_axi_rready,
  output logic [511:0] m_axi_rdata,
  output logic m_axi_rlast
);
  logic tick = 1'b0; // Toggles so a slow model answers every other cycle.
  logic [63:0] rq_addr[$]; // Accepted read bursts still owing data.
  logic [7:0] rq_len[$]; // Lengths of those bursts.
  int aw_n = 0; // Write addresses not yet answered.
  int wl_n = 0; // Last write beats not yet answered.
  int beat = 0; // Beat index inside the oldest read burst.
  initial begin
    m_axi_awready = 1'b0;
    m_axi_wready = 1'b0;
    m_axi_arready = 1'b0;
    m_axi_bvalid = 1'b0;
    m_axi_rvalid = 1'b0;
    m_axi_rlast = 1'b0;
    m_axi_rdata = '0;
  end
  // ------------------------------------------------------------
  // Channel handling; a response waits for both address and last beat.
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    tick <= ~tick;
    if (m_axi_awvalid && m_axi_awready) aw_n++;
    if (m_axi_wvalid && m_axi_wready && m_axi_wlast) wl_n++;
    if (m_axi_arvalid && m_axi_arready) begin
      rq_addr.push_back(m_axi_araddr);
      rq_len.push_back(m_axi_arlen);
    end
    m_axi_awready <= !slow || tick;
    m_axi_wready <= !slow || tick;
    m_axi_arready <= !slow || tick;
    if (!m_axi_bvalid || m_axi_bready) begin
      m_axi_bvalid <= (aw_n > 0 && wl_n > 0);
      if (aw_n > 0 && wl_n > 0) begin
        aw_n--;
        wl_n--;
      end
    end
    // Read data carries its own address so the bench can check order.
    if (!m_axi_rvalid || m_axi_rready) begin
      if (rq_addr.size() > 0 && (!slow || tick)) begin
        m_axi_rvalid <= 1'b1;
        m_axi_rdata <= {8{rq_addr[0] + 64'(beat) * 64}};
        m_axi_rlast <= (beat == int'(rq_len[0]));
        if (beat == int'(rq_len[0])) begin
          beat = 0;
          void'(rq_addr.pop_front());
          void'(rq_len.pop_front());
        end else begin
          beat++;
        end
      end else begin
        // Idle data wanders so stale beats are never mistaken for real ones.
        m_axi_rvalid <= 1'b0;
        m_axi_rlast <= 1'b0;
        m_axi_rdata <= ~m_axi_rdata;
      end
    end
  end
endmodule

// File: verif/accel_kernel_mem_master_clocking_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench for the kernel memory master.
// ------------------------------------------------------------
module accel_kernel_mem_master_clocking_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1; // Held high; freezing is not exercised.
  logic synth_locked = 1'b0;
  logic cmd_valid = 1'b0;
  kmm_pkg::cmd_s cmd = '0;
  logic [15:0] wr_avail = 16'h0;
  logic wr_valid = 1'b0;
  logic [511:0] wr_data = '0;
  logic slow = 1'b0;
  logic active_clock_id, cmd_ready, cmd_done, wr_ready, rd_valid;
  logic [511:0] rd_data, m_axi_wdata, m_axi_rdata;
  logic m_axi_awvalid, m_axi_awready, m_axi_awid, m_axi_wvalid, m_axi_wready, m_axi_wlast;
  logic m_axi_bvalid, m_axi_bready, m_axi_arvalid, m_axi_arready, m_axi_arid;
  logic m_axi_rvalid, m_axi_rready, m_axi_rlast;
  logic [63:0] m_axi_awaddr, m_axi_araddr, m_axi_wstrb;
  logic [7:0] m_axi_awlen, m_axi_arlen;
  logic [2:0] m_axi_awsize, m_axi_arsize;
  logic [1:0] m_axi_awburst, m_axi_arburst;
  int err_count = 0;
  int n_checks = 0;
  logic [71:0] bq[$]; // Bursts seen on either address channel, address above length.
  logic [63:0] wexp; // Address pattern due on the next write beat.
  logic [63:0] rexp; // Address pattern due on the next user read beat.
  logic [63:0] wend; // Address just past the last beat of the current command.
  int rd_out = 0; // Read bursts in flight.
  int rd_max = 0; // Highest read count in flight.
  kernel_mem_master u_dut (.sys_clk, .reset, .clk_en, .synth_locked, .active_clock_id, .cmd_valid,
    .cmd_ready, .cmd, .cmd_done, .wr_avail, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data,
    .m_axi_awvalid, .m_axi_awready, .m_axi_awaddr, .m_axi_awlen, .m_axi_awsize, .m_axi_awburst,
    .m_axi_awid, .m_axi_wvalid, .m_axi_wready, .m_axi_wdata, .m_axi_wstrb, .m_axi_wlast,
    .m_axi_bvalid, .m_axi_bready, .m_axi_arvalid, .m_axi_arready, .m_axi_araddr, .m_axi_arlen,
    .m_axi_arsize, .m_axi_arburst, .m_axi_arid, .m_axi_rvalid, .m_axi_rready, .m_axi_rdata,
    .m_axi_rlast);
  mem_ctrl_model u_mem (.sys_clk, .slow, .m_axi_awvalid, .m_axi_awready, .m_axi_wvalid,
    .m_axi_wready, .m_axi_wlast, .m_axi_bvalid, .m_axi_bready, .m_axi_arvalid, .m_axi_arready,
    .m_axi_araddr, .m_axi_arlen, .m_axi_rvalid, .m_axi_rready, .m_axi_rdata, .m_axi_rlast);
  // Fixed rate here; the platform may scale it, so nothing may depend on its period.
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------------------
  // Compare helpers and the single closing point.
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_wide(input string nm, input logic [511:0] e, input logic [511:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Far fewer cycles than this are needed; reaching it means a hang.
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Channel monitor, sampling before each edge's updates land.
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (m_axi_awvalid && m_axi_awready) bq.push_back({m_axi_awaddr, m_axi_awlen});
    if (m_axi_arvalid && m_axi_arready) begin
      bq.push_back({m_axi_araddr, m_axi_arlen});
      rd_out++;
    end
    if (m_axi_rvalid && m_axi_rlast) rd_out--;
    if (rd_out > rd_max) rd_max = rd_out;
    if (m_axi_awvalid) chk("awsize_burst_id", 64'h32, 64'({m_axi_awsize, m_axi_awburst, m_axi_awid}));
    if (m_axi_arvalid) chk("arsize_burst_id", 64'h32, 64'({m_axi_arsize, m_axi_arburst, m_axi_arid}));
    if (m_axi_wvalid) chk("wstrb", 64'hFFFF_FFFF_FFFF_FFFF, m_axi_wstrb);
    if (m_axi_rvalid) chk("rready", 64'h1, 64'(m_axi_rready));
    if (m_axi_wvalid && m_axi_wready) begin
      chk_wide("wdata", {8{wexp}}, m_axi_wdata);
      chk("wlast", 64'(wexp[11:6] == 6'h3F || wexp + 64'h40 == wend), 64'(m_axi_wlast));
      wexp += 64'h40;
    end
    if (rd_valid) begin
      chk_wide("rd_data", {8{rexp}}, rd_data);
      rexp += 64'h40;
    end
  end
  // Bursts must end at each 4 KB page edge and cover the command exactly.
  task automatic chk_split(input logic [63:0] a, input int n);
    int len;
    logic [71:0] e;
    while (n > 0) begin
      len = (4096 - int'(a[11:0])) / 64;
      if (len > n) len = n;
      e = (bq.size() > 0) ? bq.pop_front() : '1;
      chk("burst_addr", a, e[71:8]);
      chk("burst_len", 64'(len - 1), 64'(e[7:0]));
      a += 64'(len * 64);
      n -= len;
    end
    chk("burst_count", 64'h0, 64'(bq.size()));
  endtask
  // One command; write data is withheld for the first hold cycles.
  task automatic do_cmd(input logic wr, input logic [63:0] a, input int n, input int hold);
    int sent;
    int guard;
    logic tk;
    logic wt;
    logic dn;
    sent = 0;
    guard = 0;
    dn = 1'b0;
    wexp = a;
    rexp = a;
    wend = a + 64'(n) * 64;
    @(negedge sys_clk);
    cmd <= '{write: wr, addr: a, beats: 16'(n)};
    cmd_valid <= 1'b1;
    wr_valid <= wr && hold == 0;
    wr_data <= {8{a}};
    wr_avail <= (wr && hold == 0) ? 16'(n) : 16'h0;
    while (!dn && guard < 5000) begin
      @(posedge sys_clk);
      guard++;
      tk = cmd_valid && cmd_ready;
      wt = wr_valid && wr_ready;
      dn = (cmd_done === 1'b1);
      if (guard <= hold) chk("awvalid_early", 64'h0, 64'(m_axi_awvalid));
      @(negedge sys_clk);
      if (tk) cmd_valid <= 1'b0;
      if (wr && hold > 0 && guard == hold) begin
        wr_valid <= 1'b1;
        wr_avail <= 16'(n);
      end
      if (wt) begin
        sent++;
        wr_data <= {8{a + 64'(sent) * 64}};
        wr_avail <= 16'(n - sent);
        if (sent == n) wr_valid <= 1'b0;
      end
    end
    cmd_valid <= 1'b0;
    chk("cmd_done", 64'h1, 64'(dn));
    chk("cmd_done_pulse", 64'h0, 64'(cmd_done));
    repeat (2) @(negedge sys_clk);
    chk("beats_moved", a + 64'(n) * 64, wr ? wexp : rexp);
    chk_split(a, n);
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  // Nothing may start while the synthesizer is unlocked, even with a command waiting.
  task automatic t_lock();
    chk("clock_id", 64'h0, 64'(active_clock_id));
    cmd <= '{write: 1'b0, addr: 64'h40, beats: 16'h1};
    cmd_valid <= 1'b1;
    repeat (20) begin
      @(posedge sys_clk);
      chk("ready_unlocked", 64'h0, 64'({cmd_ready, m_axi_arvalid, m_axi_awvalid}));
    end
    @(negedge sys_clk);
    synth_locked <= 1'b1;
    do_cmd(1'b0, 64'h40, 1, 0);
  endtask
  // Three bursts across two page edges, data held back at first.
  task automatic t_write_pages();
    do_cmd(1'b1, 64'hF80, 70, 8);
  endtask
  // A full page against a controller that stalls every other cycle.
  task automatic t_write_slow();
    slow = 1'b1;
    do_cmd(1'b1, 64'h10000, 64, 0);
    slow = 1'b0;
  endtask
  // Three full pages; at least two must overlap in flight, within the outstanding ceiling.
  task automatic t_read_fast();
    rd_max = 0;
    do_cmd(1'b0, 64'h3000, 192, 0);
    chk("rd_overlap", 64'h1, 64'(rd_max >= 2 && rd_max <= 4));
  endtask
  // One-beat bursts either side of a page, with a slow controller.
  task automatic t_read_slow();
    slow = 1'b1;
    do_cmd(1'b0, 64'h5FC0, 66, 0);
    slow = 1'b0;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    reset <= 1'b0;
    t_lock();
    t_write_pages();
    t_write_slow();
    t_read_fast();
    t_read_slow();
    report_and_stop();
  end
endmodule
